//--- hdl/sbpd_pkg.sv
// Constants, types and helpers of the serial baud generator and packet-delay block
// ==========================================================================
// What this block does
// [RULE1] Main variant: baud equals an 83.329 MHz reference over 32 times the divisor.
// [RULE2] Main variant: the fastest rate is about 236.7 kBd, reached with the smallest divisor 11.
// [RULE3] Isolated variant: baud equals 7.3728 MHz over 64 times the divisor; divisor 0 gives the fixed 230.4 kBd.
// [RULE4] Current-loop variant: the port never runs above 19200 bit/s.
// [RULE5] Received bytes wait at least the network delay, in 10 ms ticks, before leaving as one packet; framed datagrams leave without it.
// [RULE6] A network delay of zero, the default, forwards received bytes at once.
// [RULE7] While the network side stalls, bytes keep piling up and may leave in a larger packet.
// [RULE8] With flush on, the default, a new connection discards the buffer; with it off the data persist.
// [RULE9] Changed settings act only on save, which stores them to non-volatile memory and applies them at once.
// [RULE10] With framing on, default off, each delimited datagram leaves whole in one packet.
// [RULE11] The divisor counter reloads on expiry and gives evenly spaced oversampling ticks.
package sbpd_pkg;

	// ==========================================================================
	// Timing
	localparam int unsigned CLK_HZ       = 100_000_000;
	localparam int unsigned REF_MAIN_HZ  = 83_329_000;
	localparam int unsigned REF_ISO_HZ   = 7_372_800;
	localparam int unsigned OVS_MAIN     = 32;
	localparam int unsigned OVS_ISO      = 64;
	localparam int unsigned DIV_MIN_MAIN = 11;
	localparam int unsigned LOOP_MAX_BD  = 19_200;
	localparam int unsigned DIV_MIN_LOOP = (REF_MAIN_HZ + OVS_MAIN * LOOP_MAX_BD - 1) / (OVS_MAIN * LOOP_MAX_BD);
	localparam int unsigned NET_TICK_MS  = 10;
	localparam int unsigned NET_TICK_CYC = NET_TICK_MS * (CLK_HZ / 1000);
	localparam int unsigned BUF_AW       = 12;

	// ==========================================================================
	// Register offsets and fields
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_DIV  = 8'h04;
	localparam logic [7:0] OFS_DLY  = 8'h08;
	localparam logic [7:0] OFS_STAT = 8'h0C;
	localparam logic [7:0] OFS_ACT  = 8'h10;
	localparam int unsigned CTRL_FLUSH_BIT = 2;
	localparam int unsigned CTRL_FRAME_BIT = 3;
	localparam int unsigned CTRL_SAVE_BIT  = 4;
	localparam int unsigned STAT_OVF_BIT   = 16;
	localparam int unsigned STAT_CLAMP_BIT = 17;
	localparam int unsigned STAT_FPEND_BIT = 18;
	localparam int unsigned STAT_CFG_LSB   = 24;

	// ==========================================================================
	// Types
	typedef enum logic [1:0] {
		V_MAIN = 2'b00,
		V_ISO  = 2'b01,
		V_LOOP = 2'b10,
		V_RSVD = 2'b11
	} sbpd_var_t;

	typedef struct packed {
		sbpd_var_t   variant;
		logic        flush_en;
		logic        frame_en;
		logic [15:0] div;
		logic [15:0] delay;
	} sbpd_cfg_t;

	typedef struct packed {
		logic       last;
		logic [7:0] data;
	} sbpd_pkt_t;

	typedef enum logic [2:0] {
		S_IDLE  = 3'b000,
		S_WAIT  = 3'b001,
		S_FETCH = 3'b010,
		S_LOAD  = 3'b011,
		S_SHOW  = 3'b100
	} sbpd_st_t;

	// Reset values
	localparam sbpd_cfg_t CFG_RST = '{variant: V_MAIN, flush_en: 1'b1, frame_en: 1'b0,
		div: 16'h0018, delay: 16'h0000};

	// Smallest divisor the variant may run with
	function automatic logic [15:0] sbpd_min_div(input sbpd_var_t v);
		case (v)
			V_LOOP:  sbpd_min_div = 16'(DIV_MIN_LOOP);
			V_ISO:   sbpd_min_div = 16'h0000;
			default: sbpd_min_div = 16'(DIV_MIN_MAIN);
		endcase
	endfunction

endpackage

//--- hdl/sbpd_ram.sv
// Byte buffer memory with registered read data
`timescale 1ns/1ps
module sbpd_ram
	import sbpd_pkg::*;
#(
	parameter int unsigned DW = 8,
	parameter int unsigned AW = BUF_AW
)
(
	// Clock
	input  wire logic          clk,
	// Write side
	input  wire logic          we,
	input  wire logic [AW-1:0] waddr,
	input  wire logic [DW-1:0] wdata,
	// Read side
	input  wire logic [AW-1:0] raddr,
	output logic      [DW-1:0] rdata_ff
);

	logic [DW-1:0] mem [0:(1<<AW)-1];

	// ==========================================================================
	// Array has no reset; read data is used only from addresses already written with buffered bytes
	always_ff @(posedge clk)
	begin
		if (we)
		begin
			mem[waddr] <= wdata;
		end
		rdata_ff <= mem[raddr];
	end

endmodule

//--- hdl/sbpd_top.sv
// Serial baud generator and delayed packet former with an APB register file
//
// The register offsets and register access over APB were left to the implementer.
`timescale 1ns/1ps
module sbpd_top
	import sbpd_pkg::*;
#(
	parameter int unsigned TICK_CYCLES = NET_TICK_CYC,
	parameter int unsigned AW          = BUF_AW
)
(
	// Clock and reset
	input  wire logic        pclk,
	input  wire logic        presetn,
	// APB slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// Received serial bytes
	input  wire logic        rx_valid,
	input  wire logic [7:0]  rx_data,
	input  wire logic        rx_frame_end,
	// Network side
	input  wire logic        conn_open,
	input  wire logic        net_ready,
	output logic             pkt_valid,
	output sbpd_pkt_t        pkt,
	// Bit-rate ticks
	output logic             ovs_tick,
	output logic             baud_tick,
	// Non-volatile store
	output logic             nvm_store,
	output sbpd_cfg_t        nvm_cfg
);

	localparam logic [AW:0] DEPTH = (AW+1)'(1 << AW);

	// ==========================================================================
	// Register file
	sbpd_cfg_t   stg_ff, nxt_stg, act_ff, nxt_act;
	logic        ovf_ff, nxt_ovf, clamp_ff, nxt_clamp, nvm_store_ff, nxt_nvm_store;
	logic [31:0] prdata_ff, nxt_prdata;
	logic        pready_ff, pslverr_ff, nxt_pslverr;
	logic        wr_acc, save, mapped, ovf_evt;
	logic [15:0] mind;

	// Datapath state; count and frame flag are declared here for the status read
	sbpd_st_t    st_ff, nxt_st;
	logic [AW:0] cnt_ff, nxt_cnt;
	logic        fpend_ff, nxt_fpend;

	assign wr_acc = psel & penable & pwrite & pready_ff;
	assign save   = wr_acc & (paddr == OFS_CTRL) & pwdata[CTRL_SAVE_BIT];
	assign mapped = (paddr == OFS_CTRL) | (paddr == OFS_DIV) | (paddr == OFS_DLY)
		| (paddr == OFS_STAT) | (paddr == OFS_ACT);
	assign mind   = sbpd_min_div(stg_ff.variant);

	// Staged writes, save, read mux; read data is built in the setup phase so pready can sit high
	always_comb
	begin
		nxt_stg       = stg_ff;
		nxt_act       = act_ff;
		nxt_clamp     = clamp_ff;
		nxt_nvm_store = 1'b0;
		nxt_ovf       = ovf_ff;
		nxt_prdata    = prdata_ff;
		nxt_pslverr   = pslverr_ff;
		if (wr_acc && paddr == OFS_CTRL)
		begin
			nxt_stg.variant  = sbpd_var_t'(pwdata[1:0]);
			nxt_stg.flush_en = pwdata[CTRL_FLUSH_BIT];
			nxt_stg.frame_en = pwdata[CTRL_FRAME_BIT];
		end
		if (wr_acc && paddr == OFS_DIV)
			nxt_stg.div = pwdata[15:0];
		if (wr_acc && paddr == OFS_DLY)
			nxt_stg.delay = pwdata[15:0];
		// Saving applies what was staged before this write, never mid-edit values
		if (save) // see [RULE9]
		begin
			nxt_act       = stg_ff;
			nxt_nvm_store = 1'b1;
			nxt_clamp     = (stg_ff.div < mind);
			if (stg_ff.variant == V_RSVD)
				nxt_act.variant = V_MAIN;
			if (stg_ff.div < mind) // see [RULE2] see [RULE4]
				nxt_act.div = mind;
		end
		// Overflow flag: a new overflow beats a clear in the same cycle
		if (wr_acc && paddr == OFS_STAT && pwdata[STAT_OVF_BIT])
			nxt_ovf = 1'b0;
		if (ovf_evt)
			nxt_ovf = 1'b1;
		if (psel && !penable)
		begin
			nxt_pslverr = ~mapped;
			nxt_prdata  = 32'h0000_0000;
			unique case (paddr)
				OFS_CTRL: nxt_prdata = {28'h0, stg_ff.frame_en, stg_ff.flush_en, stg_ff.variant};
				OFS_DIV:  nxt_prdata = {16'h0, stg_ff.div};
				OFS_DLY:  nxt_prdata = {16'h0, stg_ff.delay};
				OFS_STAT: nxt_prdata = {4'h0, act_ff.frame_en, act_ff.flush_en, act_ff.variant,
					5'h00, fpend_ff, clamp_ff, ovf_ff, 3'h0, 13'(cnt_ff)};
				OFS_ACT:  nxt_prdata = {act_ff.delay, act_ff.div};
				default:  nxt_prdata = 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			stg_ff       <= CFG_RST;
			act_ff       <= CFG_RST;
			clamp_ff     <= 1'b0;
			nvm_store_ff <= 1'b0;
			ovf_ff       <= 1'b0;
			prdata_ff    <= 32'h0000_0000;
			pready_ff    <= 1'b0;
			pslverr_ff   <= 1'b0;
		end
		else
		begin
			stg_ff       <= nxt_stg;
			act_ff       <= nxt_act;
			clamp_ff     <= nxt_clamp;
			nvm_store_ff <= nxt_nvm_store;
			ovf_ff       <= nxt_ovf;
			prdata_ff    <= nxt_prdata;
			pready_ff    <= 1'b1;
			pslverr_ff   <= nxt_pslverr;
		end
	end

	// ==========================================================================
	// Bit-rate generator: fractional step from pclk to the reference, then divisor, then oversampling
	logic [27:0] acc_ff, nxt_acc, sum;
	logic [15:0] dcnt_ff, nxt_dcnt, div_eff;
	logic [5:0]  ocnt_ff, nxt_ocnt, ovs_lim;
	logic [26:0] ref_inc;
	logic        ref_en, ovs_tick_ff, nxt_ovs_tick, baud_tick_ff, nxt_baud_tick;

	// Isolated divisor 0 is the fixed standard rate: reference over 32
	assign ref_inc = (act_ff.variant == V_ISO) ? 27'(REF_ISO_HZ) : 27'(REF_MAIN_HZ); // see [RULE1] see [RULE3]
	assign ovs_lim = (act_ff.variant == V_ISO && act_ff.div != 16'h0000) ? 6'(OVS_ISO - 1) : 6'(OVS_MAIN - 1);
	assign div_eff = (act_ff.div == 16'h0000) ? 16'h0001 : act_ff.div;
	assign sum     = acc_ff + 28'(ref_inc);
	assign ref_en  = (sum >= 28'(CLK_HZ));

	// Reload on expiry keeps ticks evenly spaced in reference cycles
	always_comb
	begin
		nxt_acc       = ref_en ? sum - 28'(CLK_HZ) : sum;
		nxt_dcnt      = dcnt_ff;
		nxt_ocnt      = ocnt_ff;
		nxt_ovs_tick  = 1'b0;
		nxt_baud_tick = 1'b0;
		if (ref_en)
		begin
			if (dcnt_ff <= 16'h0001) // see [RULE11]
			begin
				nxt_dcnt     = div_eff;
				nxt_ovs_tick = 1'b1;
			end
			else
				nxt_dcnt = dcnt_ff - 16'h0001;
		end
		if (ovs_tick_ff)
		begin
			nxt_ocnt      = (ocnt_ff >= ovs_lim) ? 6'h00 : ocnt_ff + 6'h01;
			nxt_baud_tick = (ocnt_ff >= ovs_lim);
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			acc_ff       <= 28'h0000000;
			dcnt_ff      <= 16'h0001;
			ocnt_ff      <= 6'h00;
			ovs_tick_ff  <= 1'b0;
			baud_tick_ff <= 1'b0;
		end
		else
		begin
			acc_ff       <= nxt_acc;
			dcnt_ff      <= nxt_dcnt;
			ocnt_ff      <= nxt_ocnt;
			ovs_tick_ff  <= nxt_ovs_tick;
			baud_tick_ff <= nxt_baud_tick;
		end
	end

	// ==========================================================================
	// Receive buffer and packet former
	logic [AW-1:0] wp_ff, nxt_wp, rp_ff, nxt_rp;
	logic [AW:0]   since_ff, nxt_since, flen_ff, nxt_flen, rem_ff, nxt_rem;
	logic [31:0]   tcnt_ff, nxt_tcnt;
	logic [15:0]   dly_ff, nxt_dly;
	logic [7:0]    rdata;
	logic          push, pop, flush_evt, pkt_valid_ff, nxt_pkt_valid;
	sbpd_pkt_t     pkt_ff, nxt_pkt;

	assign flush_evt = conn_open & act_ff.flush_en;
	assign push      = rx_valid & (cnt_ff != DEPTH);
	assign ovf_evt   = rx_valid & (cnt_ff == DEPTH);
	assign pop       = (st_ff == S_FETCH);

	sbpd_ram #(.DW(8), .AW(AW)) u_ram (
		.clk      (pclk),
		.we       (push),
		.waddr    (wp_ff),
		.wdata    (rx_data),
		.raddr    (rp_ff),
		.rdata_ff (rdata)
	);

	// Buffer pointers, frame bookkeeping and send sequence
	always_comb
	begin
		nxt_wp        = push ? wp_ff + 1'b1 : wp_ff;
		nxt_rp        = pop ? rp_ff + 1'b1 : rp_ff;
		nxt_cnt       = cnt_ff + (AW+1)'(push) - (AW+1)'(pop); // see [RULE7]
		nxt_since     = act_ff.frame_en ? since_ff + (AW+1)'(push) : '0; // Unframed bytes never join a datagram
		nxt_flen      = flen_ff;
		nxt_fpend     = fpend_ff;
		nxt_st        = st_ff;
		nxt_tcnt      = tcnt_ff;
		nxt_dly       = dly_ff;
		nxt_rem       = rem_ff;
		nxt_pkt       = pkt_ff;
		nxt_pkt_valid = pkt_valid_ff;
		unique case (st_ff)
			S_IDLE:
			begin
				if (act_ff.frame_en)
				begin
					if (fpend_ff && flen_ff != '0) // see [RULE10]
					begin
						nxt_fpend = 1'b0;
						nxt_rem   = flen_ff;
						nxt_st    = S_FETCH;
					end
				end
				else if (cnt_ff != '0)
				begin
					nxt_rem  = cnt_ff;
					nxt_tcnt = 32'h0000_0000;
					nxt_dly  = 16'h0000;
					nxt_st   = (act_ff.delay == 16'h0000) ? S_FETCH : S_WAIT; // see [RULE6]
				end
			end
			S_WAIT:
			begin
				// Tick phase restarts at the first byte, so the hold is never short
				if (dly_ff >= act_ff.delay) // see [RULE5]
				begin
					nxt_rem = cnt_ff;
					nxt_st  = S_FETCH;
				end
				else if (tcnt_ff >= TICK_CYCLES - 1)
				begin
					nxt_tcnt = 32'h0000_0000;
					nxt_dly  = dly_ff + 16'h0001;
				end
				else
					nxt_tcnt = tcnt_ff + 32'h0000_0001;
			end
			S_FETCH: nxt_st = S_LOAD;
			S_LOAD:
			begin
				nxt_pkt.data  = rdata;
				nxt_pkt.last  = (rem_ff == (AW+1)'(1));
				nxt_pkt_valid = 1'b1;
				nxt_st        = S_SHOW;
			end
			S_SHOW:
			begin
				if (net_ready) // see [RULE7]
				begin
					nxt_pkt_valid = 1'b0;
					nxt_rem       = rem_ff - (AW+1)'(1);
					nxt_st        = pkt_ff.last ? S_IDLE : S_FETCH;
				end
			end
			default: nxt_st = S_IDLE;
		endcase
		// Frame end latches the length of the datagram just closed; a new end beats the clear
		if (rx_frame_end && act_ff.frame_en)
		begin
			nxt_flen  = since_ff + (AW+1)'(push);
			nxt_since = '0;
			nxt_fpend = 1'b1;
		end
		// Flush drops all held bytes and any packet in flight; a byte arriving now survives
		if (flush_evt) // see [RULE8]
		begin
			nxt_rp        = wp_ff;
			nxt_cnt       = (AW+1)'(push);
			nxt_st        = S_IDLE;
			nxt_pkt_valid = 1'b0;
			if (!(rx_frame_end && act_ff.frame_en))
			begin
				nxt_since = (AW+1)'(push);
				nxt_fpend = 1'b0;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			wp_ff        <= '0;
			rp_ff        <= '0;
			cnt_ff       <= '0;
			since_ff     <= '0;
			flen_ff      <= '0;
			fpend_ff     <= 1'b0;
			st_ff        <= S_IDLE;
			tcnt_ff      <= 32'h0000_0000;
			dly_ff       <= 16'h0000;
			rem_ff       <= '0;
			pkt_ff       <= '0;
			pkt_valid_ff <= 1'b0;
		end
		else
		begin
			wp_ff        <= nxt_wp;
			rp_ff        <= nxt_rp;
			cnt_ff       <= nxt_cnt;
			since_ff     <= nxt_since;
			flen_ff      <= nxt_flen;
			fpend_ff     <= nxt_fpend;
			st_ff        <= nxt_st;
			tcnt_ff      <= nxt_tcnt;
			dly_ff       <= nxt_dly;
			rem_ff       <= nxt_rem;
			pkt_ff       <= nxt_pkt;
			pkt_valid_ff <= nxt_pkt_valid;
		end
	end

	// Outputs straight from flops
	assign prdata    = prdata_ff;
	assign pready    = pready_ff;
	assign pslverr   = pslverr_ff;
	assign pkt_valid = pkt_valid_ff;
	assign pkt       = pkt_ff;
	assign ovs_tick  = ovs_tick_ff;
	assign baud_tick = baud_tick_ff;
	assign nvm_store = nvm_store_ff;
	assign nvm_cfg   = act_ff;

	// ==========================================================================
	// Assertions
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	sequence s_last_taken;
		pkt_valid_ff && net_ready && pkt_ff.last;
	endsequence

	sequence s_save_then_store;
		save ##1 nvm_store_ff;
	endsequence

	a_main_ref_rate: assert property (act_ff.variant == V_MAIN // see [RULE1]
		|-> ref_inc == 27'(REF_MAIN_HZ) && ovs_lim == 6'h1F)
		else $error("main variant not at reference over 32");
	a_main_min_div: assert property (act_ff.variant == V_MAIN |-> act_ff.div >= 16'h000B) // see [RULE2]
		else $error("main divisor below 11");
	a_iso_ovs_rate: assert property (act_ff.variant == V_ISO && act_ff.div != 16'h0000 |-> ovs_lim == 6'h3F) // see [RULE3]
		else $error("isolated variant not oversampling by 64");
	a_loop_max_rate: assert property (act_ff.variant == V_LOOP |-> act_ff.div >= 16'(DIV_MIN_LOOP)) // see [RULE4]
		else $error("current loop faster than 19200");
	a_hold_not_short: assert property (st_ff == S_WAIT && nxt_st == S_FETCH |-> dly_ff >= act_ff.delay) // see [RULE5]
		else $error("packet left before network delay");
	a_zero_delay_send: assert property (st_ff == S_IDLE && cnt_ff != '0 && act_ff.delay == 16'h0000 // see [RULE6]
		&& !act_ff.frame_en && !flush_evt |=> st_ff == S_FETCH ##2 pkt_valid_ff)
		else $error("zero delay did not forward at once");
	a_stall_accumulate: assert property (push && !flush_evt && !pop |=> cnt_ff == $past(cnt_ff) + (AW+1)'(1)) // see [RULE7]
		else $error("byte lost while accumulating");
	a_flush_clears: assert property (flush_evt |=> cnt_ff <= (AW+1)'(1) && !pkt_valid_ff && st_ff == S_IDLE) // see [RULE8]
		else $error("buffer kept after flushing connection");
	a_keep_no_flush: assert property (conn_open && !act_ff.flush_en && !push && !pop |=> cnt_ff == $past(cnt_ff)) // see [RULE8]
		else $error("buffer lost without flush");
	a_save_applies: assert property (s_save_then_store |-> act_ff.delay == $past(stg_ff.delay, 1)) // see [RULE9]
		else $error("save did not apply staged settings");
	a_frame_whole: assert property (s_last_taken |=> st_ff == S_IDLE && !pkt_valid_ff) // see [RULE10]
		else $error("datagram packet did not close on its last byte");
	a_tick_spacing: assert property (ovs_tick_ff && act_ff.div >= 16'h0002 |=> !ovs_tick_ff) // see [RULE11]
		else $error("oversampling ticks not spaced by divisor");

endmodule

//--- testbench/sbpd_term_model.sv
// Serial terminal model that feeds received bytes into the block
`timescale 1ns/1ps
module sbpd_term_model
(
	// Clock and reset
	input  wire logic       pclk,
	input  wire logic       presetn,
	// Byte stream toward the block
	output logic            rx_valid,
	output logic [7:0]      rx_data,
	output logic            rx_frame_end
);
	// ==========================================================================
	// Idle state at time zero
	initial
	begin
		rx_valid     = 1'b0;
		rx_data      = 8'h00;
		rx_frame_end = 1'b0;
	end

	// Sends n bytes counting up from base; gap sets a prompt or slow terminal
	task automatic send(input int n, input logic [7:0] base, input int gap, input logic fend);
		logic [7:0] b;
		wait (presetn === 1'b1); // No byte while the block is held in reset
		for (int i = 0; i < n; i++)
		begin
			b = base + 8'(i);
			@(posedge pclk);
			rx_valid     <= 1'b1;
			rx_data      <= b;
			rx_frame_end <= fend && (i == n - 1);
			@(posedge pclk);
			rx_valid     <= 1'b0;
			rx_frame_end <= 1'b0;
			rx_data      <= ~b; // Stale data must never look valid
			repeat (gap) @(posedge pclk);
		end
	endtask
endmodule

//--- testbench/test_serial_baud_and_packet_delay.sv
// Self-checking bench of the baud generator and packet-delay block
`timescale 1ns/1ps
module test_serial_baud_and_packet_delay
	import sbpd_pkg::*;
;
	// ==========================================================================
	// Signals
	localparam int unsigned TICKS = 20; // Short net tick keeps delays cheap
	logic        pclk = 1'b0;
	logic        presetn = 1'b0;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        rx_valid;
	logic [7:0]  rx_data;
	logic        rx_frame_end;
	logic        conn_open = 1'b0;
	logic        net_ready = 1'b0;
	logic        pkt_valid;
	sbpd_pkt_t   pkt;
	logic        ovs_tick;
	logic        baud_tick;
	logic        nvm_store;
	sbpd_cfg_t   nvm_cfg;
	int          miscompares = 0;
	int          checks = 0;
	int          cyc = 0;
	int          stores = 0;
	logic [31:0] rd;
	logic        err;
	int          t0;

	// ==========================================================================
	// Design, terminal and clock
	sbpd_top #(.TICK_CYCLES(TICKS), .AW(4)) DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.rx_valid(rx_valid), .rx_data(rx_data), .rx_frame_end(rx_frame_end), .conn_open(conn_open),
		.net_ready(net_ready), .pkt_valid(pkt_valid), .pkt(pkt), .ovs_tick(ovs_tick), .baud_tick(baud_tick),
		.nvm_store(nvm_store), .nvm_cfg(nvm_cfg));
	sbpd_term_model term (.pclk(pclk), .presetn(presetn), .rx_valid(rx_valid), .rx_data(rx_data),
		.rx_frame_end(rx_frame_end));

	// Free-running clock
	always #5 pclk = ~pclk;

	// Cycle and store-pulse counters
	always @(posedge pclk)
	begin
		cyc <= cyc + 1;
		if (nvm_store === 1'b1)
			stores <= stores + 1;
	end

	// ==========================================================================
	// Tasks
	task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp)
		begin
			miscompares++;
			$display("wrong value %s expected %h seen %h", name, exp, seen);
		end
	endtask

	// One APB transfer; waits for pready, takes read data at that edge
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= wr;
		paddr   <= a;
		pwdata  <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do
			@(posedge pclk);
		while (pready !== 1'b1);
		rd  = prdata;
		err = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask

	// Stages settings, then saves them with a second control write
	task automatic save(input logic [3:0] ctrl, input logic [15:0] div, input logic [15:0] dly);
		apb(1'b1, OFS_DIV, {16'h0, div});
		apb(1'b1, OFS_DLY, {16'h0, dly});
		apb(1'b1, OFS_CTRL, {28'h0, ctrl});
		apb(1'b1, OFS_CTRL, {27'h0, 1'b1, ctrl});
		repeat (3) @(posedge pclk);
	endtask

	// Takes n bytes from the network side and checks order and last flag
	task automatic take(input int n, input logic [7:0] base);
		int w;
		net_ready <= 1'b1;
		for (int i = 0; i < n; i++)
		begin
			w = 0;
			do
			begin
				@(posedge pclk);
				w++;
			end
			while (!(pkt_valid === 1'b1 && net_ready === 1'b1) && w < 3000);
			chk("pkt", {23'h0, pkt}, {23'h0, i == n - 1, base + 8'(i)});
		end
		net_ready <= 1'b0;
	endtask

	// Counts ovs ticks between baud ticks and checks even tick spacing
	task automatic baud(input int per);
		int n;
		int last;
		@(posedge pclk iff baud_tick === 1'b1);
		n = 0;
		last = cyc - 1; // The tick that closed the last baud period was seen one edge earlier
		do
		begin
			@(posedge pclk);
			if (ovs_tick === 1'b1)
			begin
				chk("ovs gap", 32'(cyc - last >= 13 && cyc - last <= 14), 32'h1);
				last = cyc;
				n++;
			end
		end
		while (baud_tick !== 1'b1);
		chk("ovs per baud", 32'(n), 32'(per));
	endtask

	task automatic wrap_up;
		$display("checks %0d miscompares %0d", checks, miscompares);
		if (miscompares == 0 && checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	// ==========================================================================
	// Watchdog against a hung handshake
	initial
	begin
		repeat (60000) @(posedge pclk);
		miscompares++;
		wrap_up();
	end

	// ==========================================================================
	// Test sequence
	initial
	begin
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		repeat (2) @(posedge pclk);
		// Reset values, unmapped access, staging without save
		chk("cfg", nvm_cfg[31:0], CFG_RST[31:0]);
		chk("cfg top", 32'(nvm_cfg[35:32]), 32'(CFG_RST[35:32]));
		apb(1'b0, OFS_CTRL, 32'h0);
		chk("ctrl", rd, 32'h0000_0004);
		apb(1'b0, 8'h14, 32'h0);
		chk("slverr", {31'h0, err}, 32'h1);
		apb(1'b1, OFS_DIV, 32'h0000_0005);
		apb(1'b0, OFS_ACT, 32'h0);
		chk("act unsaved", rd, 32'h0000_0018);
		chk("stores", 32'(stores), 32'h0);
		$display("test reset done");
		// Main variant clamp and tick spacing
		save(4'h4, 16'h0005, 16'h0000);
		chk("stores", 32'(stores), 32'h1);
		apb(1'b0, OFS_ACT, 32'h0);
		chk("act main", rd, 32'h0000_000B);
		apb(1'b0, OFS_STAT, 32'h0);
		chk("clamp", {31'h0, rd[STAT_CLAMP_BIT]}, 32'h1);
		baud(OVS_MAIN);
		$display("test main baud done");
		// Current loop clamp, isolated variant at divisor 1
		save(4'h6, 16'h0005, 16'h0000);
		apb(1'b0, OFS_ACT, 32'h0);
		chk("act loop", rd, 32'h0000_0088);
		save(4'h5, 16'h0001, 16'h0000);
		baud(OVS_ISO);
		$display("test variants done");
		// Zero delay forwards at once
		save(4'h4, 16'h000B, 16'h0000);
		net_ready <= 1'b1;
		term.send(1, 8'h3C, 2, 1'b0);
		t0 = cyc;
		take(1, 8'h3C);
		chk("fast", 32'(cyc - t0 <= 8), 32'h1);
		// Delay of two ticks, network stalled, bytes gathered into one packet
		save(4'h4, 16'h000B, 16'h0002);
		t0 = cyc;
		term.send(3, 8'h50, 4, 1'b0);
		@(posedge pclk iff pkt_valid === 1'b1);
		chk("held", 32'(cyc - t0 >= 2 * TICKS), 32'h1);
		repeat (60) @(posedge pclk);
		take(3, 8'h50);
		$display("test delay done");
		// Flush on: new connection empties buffer
		save(4'h4, 16'h000B, 16'h0000);
		term.send(2, 8'hA0, 2, 1'b0);
		@(posedge pclk);
		conn_open <= 1'b1;
		@(posedge pclk);
		conn_open <= 1'b0;
		repeat (2) @(posedge pclk);
		chk("flushed", {31'h0, pkt_valid}, 32'h0);
		apb(1'b0, OFS_STAT, 32'h0);
		chk("count", {19'h0, rd[12:0]}, 32'h0);
		term.send(1, 8'hB0, 2, 1'b0);
		take(1, 8'hB0);
		// Flush off: data survive the new connection
		save(4'h0, 16'h000B, 16'h0000);
		term.send(2, 8'hC0, 2, 1'b0);
		@(posedge pclk);
		conn_open <= 1'b1;
		@(posedge pclk);
		conn_open <= 1'b0;
		take(1, 8'hC0);
		@(posedge pclk); // Ready falls for one edge so the next take never drives it twice at once
		take(1, 8'hC1);
		$display("test flush done");
		// Overflow: a long hold fills the 16-byte buffer, one byte too many, then flush empties it
		save(4'h4, 16'h000B, 16'h0FFF);
		term.send(17, 8'h60, 0, 1'b0);
		apb(1'b0, OFS_STAT, 32'h0);
		chk("full", {19'h0, rd[12:0]}, 32'h0000_0010);
		chk("ovf", {31'h0, rd[STAT_OVF_BIT]}, 32'h1);
		apb(1'b1, OFS_STAT, 32'h0001_0000);
		apb(1'b0, OFS_STAT, 32'h0);
		chk("ovf clear", {31'h0, rd[STAT_OVF_BIT]}, 32'h0);
		@(posedge pclk);
		conn_open <= 1'b1;
		@(posedge pclk);
		conn_open <= 1'b0;
		$display("test overflow done");
		// Framing: one datagram leaves whole, delay ignored
		save(4'hC, 16'h000B, 16'h0003);
		term.send(4, 8'h10, 3, 1'b1);
		take(4, 8'h10);
		$display("test framing done");
		wrap_up();
	end
endmodule
